// ===== core/csb_exec.v
// Execution unit for stack, branch, skip and CPU-control instructions
`timescale 1ns/10ps
`default_nettype none
`include "csb_regs.vh"

module csb_exec #(
  parameter PC_W = 20,
  parameter SP_W = 16
) (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // Instruction issue
  input wire i_start,
  input wire [4:0] i_op,
  input wire [7:0] i_disp8,
  input wire [15:0] i_disp16,
  input wire [7:0] i_imm8,
  input wire [15:0] i_imm16,
  input wire [15:0] i_rp_val,
  input wire [1:0] i_bank,
  input wire [2:0] i_bit_mode,
  input wire [2:0] i_bit_idx,
  input wire i_bit_val,
  input wire i_pmem,
  // Stack memory read port, word at o_stack_ptr and o_stack_ptr+1
  input wire [15:0] i_stk_word,
  // Direct state writes from the rest of the core
  input wire i_pc_wr,
  input wire [PC_W-1:0] i_pc_wdata,
  input wire i_flag_wr,
  input wire [7:0] i_flag_wdata,
  // Standby release
  input wire i_wake,
  // Sequencing
  output reg o_busy,
  output reg o_done,
  output reg o_taken,
  output reg o_skip,
  output reg o_bad_op,
  // Architectural state
  output reg [PC_W-1:0] o_pc,
  output reg [SP_W-1:0] o_stack_ptr,
  output reg [7:0] o_psw,
  // Stack memory write port, word at o_stk_waddr and +1
  output reg o_stk_we,
  output reg [SP_W-1:0] o_stk_waddr,
  output reg [15:0] o_stk_wdata,
  // Register pair load and bit clear
  output reg o_rp_load,
  output reg [15:0] o_rp_data,
  output reg o_bit_clr,
  // Standby modes
  output reg o_halt,
  output reg o_stop
);

  // ==========================================================
  // Cycle counter
  reg [3:0] cnt;

  // ==========================================================
  // Decode
  wire accept;
  wire flag_z;
  wire flag_cy;
  wire flag_zc;
  wire psw_bit;
  wire test_bit;
  wire [PC_W-1:0] disp8_ext;
  wire [PC_W-1:0] disp16_ext;

  assign accept = i_start & ~o_busy & ~o_halt & ~o_stop;
  assign flag_z = o_psw[`CSB_PSW_Z];
  assign flag_cy = o_psw[`CSB_PSW_CY];
  assign flag_zc = flag_z | flag_cy;
  assign psw_bit = o_psw[i_bit_idx];
  assign test_bit = (i_bit_mode == `CSB_BM_PSW) ? psw_bit : i_bit_val;
  assign disp8_ext = {{(PC_W-8){i_disp8[7]}}, i_disp8};
  assign disp16_ext = {{(PC_W-16){i_disp16[15]}}, i_disp16};

  reg [3:0] cyc_nt;
  reg [3:0] cyc_t;
  reg cond;
  reg is_cond;
  reg is_jump;
  reg long_disp;
  reg [2:0] len;
  reg [3:0] cyc;
  reg [PC_W-1:0] next_pc;
  reg [SP_W-1:0] next_sp;
  reg [7:0] next_psw;
  reg next_we;
  reg [SP_W-1:0] next_waddr;
  reg [15:0] next_wdata;
  reg next_rp_load;
  reg [15:0] next_rp_data;
  reg next_bit_clr;
  reg next_skip;
  reg next_halt;
  reg next_stop;
  reg next_bad;

  // Bit-test timing depends on where the operand lives
  always @* begin
    cyc_nt = `CSB_CYC_BIT_NT;
    cyc_t = `CSB_CYC_BIT_T;
    case (i_bit_mode)
      `CSB_BM_ESHL: begin
        if (i_pmem && i_op != `CSB_OP_JBTCLR) begin
          cyc_nt = `CSB_CYC_ESHL_PM_NT;
          cyc_t = `CSB_CYC_ESHL_PM_T;
        end else begin
          cyc_nt = `CSB_CYC_ESHL_NT;
          cyc_t = `CSB_CYC_ESHL_T;
        end
      end
      `CSB_BM_HL: begin
        if (i_pmem && i_op != `CSB_OP_JBTCLR) begin
          cyc_nt = `CSB_CYC_HL_PM_NT;
          cyc_t = `CSB_CYC_HL_PM_T;
        end
      end
      `CSB_BM_PSW: begin
        if (i_op == `CSB_OP_JBTCLR) begin
          cyc_nt = `CSB_CYC_CLRPSW_NT;
          cyc_t = `CSB_CYC_CLRPSW_T;
        end
      end
      default: begin
        cyc_nt = `CSB_CYC_BIT_NT;
        cyc_t = `CSB_CYC_BIT_T;
      end
    endcase
  end

  always @* begin
    cond = 1'b0;
    is_cond = 1'b0;
    is_jump = 1'b0;
    long_disp = 1'b0;
    len = `CSB_LEN2;
    cyc = `CSB_CYC_ONE;
    next_sp = o_stack_ptr;
    next_psw = o_psw;
    next_we = 1'b0;
    next_waddr = o_stk_waddr;
    next_wdata = o_stk_wdata;
    next_rp_load = 1'b0;
    next_rp_data = o_rp_data;
    next_bit_clr = 1'b0;
    next_skip = 1'b0;
    next_halt = 1'b0;
    next_stop = 1'b0;
    next_bad = 1'b0;
    case (i_op)
      `CSB_OP_NOP: begin
        len = `CSB_LEN1;
      end
      `CSB_OP_PUSH_PSW: begin
        next_we = 1'b1;
        next_waddr = o_stack_ptr - 16'h0002;
        next_wdata = {o_psw, 8'h00};
        next_sp = o_stack_ptr - 16'h0002;
      end
      `CSB_OP_PUSH_RP: begin
        len = `CSB_LEN1;
        next_we = 1'b1;
        next_waddr = o_stack_ptr - 16'h0002;
        next_wdata = i_rp_val;
        next_sp = o_stack_ptr - 16'h0002;
      end
      `CSB_OP_POP_PSW: begin
        cyc = `CSB_CYC_POP_PSW;
        next_psw = i_stk_word[15:8];
        next_sp = o_stack_ptr + 16'h0002;
      end
      `CSB_OP_POP_RP: begin
        len = `CSB_LEN1;
        next_rp_load = 1'b1;
        next_rp_data = i_stk_word;
        next_sp = o_stack_ptr + 16'h0002;
      end
      `CSB_OP_SP_LOAD: begin
        len = `CSB_LEN4;
        next_sp = i_imm16;
      end
      `CSB_OP_SP_ADD: begin
        next_sp = o_stack_ptr + {8'h00, i_imm8};
      end
      `CSB_OP_SP_SUB: begin
        next_sp = o_stack_ptr - {8'h00, i_imm8};
      end
      `CSB_OP_JMP_SHORT: begin
        is_jump = 1'b1;
        cyc = `CSB_CYC_JMP;
      end
      `CSB_OP_JMP_LONG: begin
        is_jump = 1'b1;
        long_disp = 1'b1;
        len = `CSB_LEN3;
        cyc = `CSB_CYC_JMP;
      end
      `CSB_OP_JC, `CSB_OP_JNC, `CSB_OP_JZ, `CSB_OP_JNZ: begin
        is_cond = 1'b1;
        case (i_op)
          `CSB_OP_JC: cond = flag_cy;
          `CSB_OP_JNC: cond = ~flag_cy;
          `CSB_OP_JZ: cond = flag_z;
          default: cond = ~flag_z;
        endcase
        cyc = cond ? `CSB_CYC_JCC_T : `CSB_CYC_JCC_NT;
      end
      `CSB_OP_JH, `CSB_OP_JNH: begin
        is_cond = 1'b1;
        len = `CSB_LEN3;
        cond = (i_op == `CSB_OP_JH) ? ~flag_zc : flag_zc;
        cyc = cond ? `CSB_CYC_JCC_T : `CSB_CYC_JCC_NT;
      end
      `CSB_OP_JBT, `CSB_OP_JBF, `CSB_OP_JBTCLR: begin
        is_cond = 1'b1;
        if (i_bit_mode == `CSB_BM_ACC || i_bit_mode == `CSB_BM_HL) begin
          len = `CSB_LEN3;
        end else begin
          len = `CSB_LEN4;
        end
        cond = (i_op == `CSB_OP_JBF) ? ~test_bit : test_bit;
        cyc = cond ? cyc_t : cyc_nt;
        if (i_op == `CSB_OP_JBTCLR && cond) begin
          // Status bits are cleared here, any other bit by its owner
          if (i_bit_mode == `CSB_BM_PSW) begin
            next_psw[i_bit_idx] = 1'b0;
          end else begin
            next_bit_clr = 1'b1;
          end
        end
        if (i_bit_mode > `CSB_BM_ESHL) begin
          next_bad = 1'b1;
        end
      end
      `CSB_OP_SKC, `CSB_OP_SKIP_ON_NO_CARRY: begin
        next_skip = (i_op == `CSB_OP_SKC) ? flag_cy : ~flag_cy;
      end
      `CSB_OP_SKZ, `CSB_OP_SKIP_ON_NONZERO: begin
        next_skip = (i_op == `CSB_OP_SKZ) ? flag_z : ~flag_z;
      end
      `CSB_OP_SKH, `CSB_OP_SKIP_ON_NOT_HIGHER: begin
        next_skip = (i_op == `CSB_OP_SKH) ? ~flag_zc : flag_zc;
      end
      `CSB_OP_SEL: begin
        next_psw[`CSB_PSW_RBS1] = i_bank[1];
        next_psw[`CSB_PSW_RBS0] = i_bank[0];
      end
      `CSB_OP_EI, `CSB_OP_DI: begin
        len = `CSB_LEN3;
        cyc = `CSB_CYC_EI_DI;
        next_psw[`CSB_PSW_IE] = (i_op == `CSB_OP_EI);
      end
      `CSB_OP_HALT: begin
        cyc = `CSB_CYC_STBY;
        next_halt = 1'b1;
      end
      `CSB_OP_STOP: begin
        cyc = `CSB_CYC_STBY;
        next_stop = 1'b1;
      end
      default: begin
        // Unknown codes retire as a one-byte no-op and are flagged
        len = `CSB_LEN1;
        next_bad = 1'b1;
      end
    endcase
  end

  // ==========================================================
  // Next program counter
  always @* begin
    next_pc = o_pc + {{(PC_W-3){1'b0}}, len};
    if (is_jump || (is_cond && cond)) begin
      if (long_disp) begin
        next_pc = o_pc + {{(PC_W-3){1'b0}}, len} + disp16_ext;
      end else begin
        next_pc = o_pc + {{(PC_W-3){1'b0}}, len} + disp8_ext;
      end
    end
  end

  // ==========================================================
  // Sequencing: state commits at the accept edge, o_done marks the
  // last cycle so the issuing side sees the documented occupancy
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt <= 4'h0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_taken <= 1'b0;
      o_skip <= 1'b0;
      o_bad_op <= 1'b0;
    end else if (accept) begin
      cnt <= cyc - 4'h1;
      o_busy <= (cyc != `CSB_CYC_ONE);
      o_done <= (cyc == `CSB_CYC_ONE);
      o_taken <= is_jump | (is_cond & cond);
      o_skip <= next_skip;
      o_bad_op <= next_bad;
    end else begin
      if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end
      o_busy <= (cnt > 4'h1);
      o_done <= (cnt == 4'h1);
      o_skip <= 1'b0;
      if (cnt == 4'h0) begin
        o_taken <= 1'b0;
        o_bad_op <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Architectural state; an instruction wins over a direct write
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_pc <= `CSB_PC_RST;
      o_stack_ptr <= `CSB_SP_RST;
      o_psw <= `CSB_PSW_RST;
    end else if (accept) begin
      o_pc <= next_pc;
      o_stack_ptr <= next_sp;
      o_psw <= next_psw;
    end else begin
      if (i_pc_wr) begin
        o_pc <= i_pc_wdata;
      end
      if (i_flag_wr) begin
        o_psw <= i_flag_wdata;
      end
    end
  end

  // ==========================================================
  // Memory side pulses
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_stk_we <= 1'b0;
      o_stk_waddr <= `CSB_SP_RST;
      o_stk_wdata <= 16'h0000;
      o_rp_load <= 1'b0;
      o_rp_data <= 16'h0000;
      o_bit_clr <= 1'b0;
    end else if (accept) begin
      o_stk_we <= next_we;
      o_stk_waddr <= next_waddr;
      o_stk_wdata <= next_wdata;
      o_rp_load <= next_rp_load;
      o_rp_data <= next_rp_data;
      o_bit_clr <= next_bit_clr;
    end else begin
      o_stk_we <= 1'b0;
      o_rp_load <= 1'b0;
      o_bit_clr <= 1'b0;
    end
  end

  // ==========================================================
  // Standby: entered at the accept edge, left only on wake; new
  // instructions are refused until then
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_halt <= 1'b0;
      o_stop <= 1'b0;
    end else if (accept) begin
      o_halt <= next_halt;
      o_stop <= next_stop;
    end else if (i_wake && !o_busy) begin
      o_halt <= 1'b0;
      o_stop <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ===== core/csb_regs.vh
// Constants for the stack, branch and CPU-control execution unit
`ifndef CSB_REGS_VH
`define CSB_REGS_VH
// Operation codes presented on i_op
`define CSB_OP_NOP 5'h00
`define CSB_OP_PUSH_PSW 5'h01
`define CSB_OP_PUSH_RP 5'h02
`define CSB_OP_POP_PSW 5'h03
`define CSB_OP_POP_RP 5'h04
`define CSB_OP_SP_LOAD 5'h05
`define CSB_OP_SP_ADD 5'h06
`define CSB_OP_SP_SUB 5'h07
`define CSB_OP_JMP_SHORT 5'h08
`define CSB_OP_JMP_LONG 5'h09
`define CSB_OP_JC 5'h0A
`define CSB_OP_JNC 5'h0B
`define CSB_OP_JZ 5'h0C
`define CSB_OP_JNZ 5'h0D
`define CSB_OP_JH 5'h0E
`define CSB_OP_JNH 5'h0F
`define CSB_OP_JBT 5'h10
`define CSB_OP_JBF 5'h11
`define CSB_OP_JBTCLR 5'h12
`define CSB_OP_SKC 5'h13
`define CSB_OP_SKIP_ON_NO_CARRY 5'h14
`define CSB_OP_SKZ 5'h15
`define CSB_OP_SKIP_ON_NONZERO 5'h16
`define CSB_OP_SKH 5'h17
`define CSB_OP_SKIP_ON_NOT_HIGHER 5'h18
`define CSB_OP_SEL 5'h19
`define CSB_OP_EI 5'h1A
`define CSB_OP_DI 5'h1B
`define CSB_OP_HALT 5'h1C
`define CSB_OP_STOP 5'h1D
// Bit operand sources for the bit-test branches
`define CSB_BM_SADDR 3'h0
`define CSB_BM_SFR 3'h1
`define CSB_BM_ACC 3'h2
`define CSB_BM_PSW 3'h3
`define CSB_BM_HL 3'h4
`define CSB_BM_ESHL 3'h5
// Status word field positions and reset value
`define CSB_PSW_IE 7
`define CSB_PSW_Z 6
`define CSB_PSW_RBS1 5
`define CSB_PSW_AC 4
`define CSB_PSW_RBS0 3
`define CSB_PSW_CY 0
`define CSB_PSW_RST 8'h00
`define CSB_SP_RST 16'h0000
`define CSB_PC_RST 20'h00000
// Encoding lengths in bytes
`define CSB_LEN1 3'h1
`define CSB_LEN2 3'h2
`define CSB_LEN3 3'h3
`define CSB_LEN4 3'h4
// Cycle counts, not-taken / taken where paired
`define CSB_CYC_ONE 4'h1
`define CSB_CYC_POP_PSW 4'h3
`define CSB_CYC_JMP 4'h3
`define CSB_CYC_JCC_NT 4'h2
`define CSB_CYC_JCC_T 4'h4
`define CSB_CYC_BIT_NT 4'h3
`define CSB_CYC_BIT_T 4'h5
`define CSB_CYC_ESHL_NT 4'h4
`define CSB_CYC_ESHL_T 4'h6
`define CSB_CYC_HL_PM_NT 4'h6
`define CSB_CYC_HL_PM_T 4'h8
`define CSB_CYC_ESHL_PM_NT 4'h7
`define CSB_CYC_ESHL_PM_T 4'h9
`define CSB_CYC_CLRPSW_NT 4'h5
`define CSB_CYC_CLRPSW_T 4'h7
`define CSB_CYC_EI_DI 4'h4
`define CSB_CYC_STBY 4'h3
`endif

// ===== bench/csb_exec_sva.sv
// Concurrent checks on the ports of the execution unit
`timescale 1ns/10ps
`default_nettype none
`include "csb_regs.vh"
module csb_exec_sva #(
  parameter PC_W = 20,
  parameter SP_W = 16
) (
  // Clock, reset and issue
  input wire i_clk,
  input wire i_rst_n,
  input wire i_start,
  input wire [4:0] i_op,
  input wire [7:0] i_disp8,
  input wire [15:0] i_rp_val,
  input wire [2:0] i_bit_mode,
  input wire i_bit_val,
  input wire [15:0] i_stk_word,
  // Unit outputs
  input wire o_busy,
  input wire o_done,
  input wire o_taken,
  input wire o_skip,
  input wire o_halt,
  input wire o_stop,
  input wire [PC_W-1:0] o_pc,
  input wire [SP_W-1:0] o_stack_ptr,
  input wire [7:0] o_psw,
  input wire o_stk_we,
  input wire [SP_W-1:0] o_stk_waddr,
  input wire [15:0] o_stk_wdata,
  input wire o_bit_clr
);
  // Same condition the unit uses to take a request
  wire acc = i_start && !o_busy && !o_halt && !o_stop;
  wire cy = o_psw[`CSB_PSW_CY];
  wire zf = o_psw[`CSB_PSW_Z];
  wire [PC_W-1:0] sx8 = {{(PC_W-8){i_disp8[7]}}, i_disp8};
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  a_push_pair: assert property (
    acc && i_op == `CSB_OP_PUSH_RP |-> ##1 (o_stk_we && o_done &&
    o_stk_waddr == $past(o_stack_ptr) - 16'h2 &&
    o_stack_ptr == o_stk_waddr && o_stk_wdata == $past(i_rp_val)))
    else $error("pair push wrong");
  a_pop_status: assert property (
    acc && i_op == `CSB_OP_POP_PSW |-> ##1 (o_busy &&
    {o_psw, 8'h00} == ($past(i_stk_word) & 16'hFF00) &&
    o_stack_ptr == $past(o_stack_ptr) + 16'h2) ##1 o_busy
    ##1 (o_done && !o_busy))
    else $error("status pop wrong");
  a_short_jump: assert property (
    acc && i_op == `CSB_OP_JMP_SHORT |->
    ##1 (o_pc == $past(o_pc) + 20'h2 + $past(sx8)) ##2 o_done)
    else $error("short jump wrong");
  a_carry_taken: assert property (
    acc && i_op == `CSB_OP_JC && cy |->
    ##1 o_taken [*3] ##1 (o_done && o_taken))
    else $error("carry jump timing wrong");
  a_higher_fail: assert property (
    acc && i_op == `CSB_OP_JH && (zf || cy) |-> ##1 (!o_taken && !o_done)
    ##1 (o_done && o_pc == $past(o_pc, 2) + 20'h3))
    else $error("higher jump wrong");
  a_carry_skip: assert property (
    acc && i_op == `CSB_OP_SKC |-> ##1 (o_done && o_skip == $past(cy)))
    else $error("carry skip wrong");
  a_int_enable: assert property (
    acc && i_op == `CSB_OP_EI |-> ##1 o_psw[`CSB_PSW_IE] ##3 o_done)
    else $error("interrupt enable wrong");
  a_clear_bit: assert property (
    acc && i_op == `CSB_OP_JBTCLR && i_bit_mode != `CSB_BM_PSW &&
    i_bit_val |-> ##1 (o_bit_clr && o_taken))
    else $error("bit clear missing");
endmodule
bind csb_exec csb_exec_sva #(.PC_W(PC_W), .SP_W(SP_W)) sva_u (.*);
`default_nettype wire

// ===== bench/csb_stack_mem.sv
// Byte-wide stack memory standing at the far side of the unit
`timescale 1ns/10ps
`default_nettype none
module csb_stack_mem (
  // Clock and write port
  input wire logic i_clk,
  input wire logic i_we,
  input wire logic [15:0] i_addr,
  input wire logic [15:0] i_data,
  // Read port at the stack pointer
  input wire logic [15:0] i_sp,
  output logic [15:0] o_word
);
  logic [7:0] mem [0:65535];
  // Low byte goes to the lower address
  always @(posedge i_clk) begin
    if (i_we) begin
      mem[i_addr] <= i_data[7:0];
      mem[i_addr + 16'h1] <= i_data[15:8];
    end
  end
  assign o_word = {mem[i_sp + 16'h1], mem[i_sp]};
endmodule
`default_nettype wire

// ===== bench/test_cpu_stack_branch_control_ops.sv
// Self-checking bench for the stack, branch and control unit
`timescale 1ns/10ps
`default_nettype none
`include "csb_regs.vh"
module test_cpu_stack_branch_control_ops;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_start = 1'b0;
  logic [4:0] i_op = 5'h00;
  logic [7:0] i_disp8 = 8'hF0;
  logic [15:0] i_disp16 = 16'h0100;
  logic [7:0] i_imm8 = 8'h10;
  logic [15:0] i_imm16 = 16'h1000;
  logic [15:0] i_rp_val = 16'h0000;
  logic [1:0] i_bank = 2'h0;
  logic [2:0] i_bit_mode = 3'h0;
  logic [2:0] i_bit_idx = 3'h4;
  logic i_bit_val = 1'b0;
  logic i_pmem = 1'b0;
  logic i_pc_wr = 1'b0;
  logic [19:0] i_pc_wdata = 20'h00000;
  logic i_flag_wr = 1'b0;
  logic [7:0] i_flag_wdata = 8'h00;
  logic i_wake = 1'b0;
  logic o_busy, o_done, o_taken, o_skip, o_bad_op, o_stk_we;
  logic o_rp_load, o_bit_clr, o_halt, o_stop, sk, cl, tk, bd, rl;
  logic [19:0] o_pc;
  logic [15:0] o_stack_ptr, o_stk_waddr, o_stk_wdata, o_rp_data, rd;
  logic [15:0] i_stk_word;
  logic [7:0] o_psw;
  int fails = 0;
  int samples_checked = 0;
  always #2 i_clk = ~i_clk;
  csb_exec dut_u (.*);
  csb_stack_mem mem_u (.i_clk(i_clk), .i_we(o_stk_we), .i_addr(o_stk_waddr),
    .i_data(o_stk_wdata), .i_sp(o_stack_ptr), .o_word(i_stk_word));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      $display("Error at %0t: got %h expected %h", $time, g, e);
      fails++;
    end
  endtask
  task automatic test_done;
    $display("Checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Flags are loaded one cycle ahead, since a write on the accept edge is lost
  task automatic go(input logic [4:0] op, input logic [7:0] f,
    input int c, input logic [19:0] d, input logic k);
    logic [19:0] pc0;
    logic [19:0] dp;
    int n;
    pc0 = o_pc;
    @(posedge i_clk);
    i_flag_wr <= 1'b1;
    i_flag_wdata <= f;
    @(posedge i_clk);
    i_flag_wr <= 1'b0;
    i_start <= 1'b1;
    i_op <= op;
    @(posedge i_clk);
    i_start <= 1'b0;
    // The accept edge is the one just passed: look at cycle 1 first
    for (n = 1; n < 13; n++) begin
      #1;
      if (n == 1) begin
        sk = o_skip;
        cl = o_bit_clr;
        tk = o_taken;
        rd = o_rp_data;
        bd = o_bad_op;
        rl = o_rp_load;
      end
      if (o_done === 1'b1) break;
      @(posedge i_clk);
    end
    if (n == 13) begin
      fails++;
      test_done();
    end
    dp = o_pc - pc0;
    chk(n, c);
    chk(dp, d);
    chk(tk, k);
  endtask
  task automatic bj(input logic [4:0] op, input logic [2:0] m,
    input logic v, input logic p, input int c, input logic [19:0] d);
    i_bit_mode <= m;
    i_bit_val <= v;
    i_pmem <= p;
    go(op, 8'h00, c, d, d[19]);
  endtask
  task automatic skp(input logic [4:0] op, input logic [7:0] f, input logic e);
    go(op, f, 1, 20'h2, 1'b0);
    chk(sk, e);
  endtask
  // Standby must refuse a start until woken
  task automatic stby(input logic [4:0] op, input logic h);
    logic [19:0] pc0;
    go(op, 8'h00, 3, 20'h2, 1'b0);
    chk({o_halt, o_stop}, {h, ~h});
    pc0 = o_pc;
    @(posedge i_clk);
    i_start <= 1'b1;
    i_op <= `CSB_OP_NOP;
    repeat (2) @(posedge i_clk);
    i_start <= 1'b0;
    i_wake <= 1'b1;
    @(posedge i_clk);
    i_wake <= 1'b0;
    #1;
    chk(o_pc, pc0);
    chk({o_halt, o_stop}, 2'b00);
  endtask
  initial begin
    repeat (20) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    #1;
    chk(o_pc, 20'h00000);
    chk({o_stack_ptr, o_psw}, 24'h000000);
    go(`CSB_OP_SP_LOAD, 8'h00, 1, 20'h4, 1'b0);
    go(`CSB_OP_SP_ADD, 8'h00, 1, 20'h2, 1'b0);
    chk(o_stack_ptr, 16'h1010);
    i_imm8 <= 8'h20;
    go(`CSB_OP_SP_SUB, 8'h00, 1, 20'h2, 1'b0);
    chk(o_stack_ptr, 16'h0FF0);
    go(`CSB_OP_PUSH_PSW, 8'h51, 1, 20'h2, 1'b0);
    @(posedge i_clk);
    i_start <= 1'b1;
    i_op <= `CSB_OP_PUSH_RP;
    i_rp_val <= 16'hA55A;
    @(posedge i_clk);
    i_rp_val <= 16'h1234;
    @(posedge i_clk);
    i_start <= 1'b0;
    @(posedge i_clk);
    #1;
    chk(o_stack_ptr, 16'h0FEA);
    chk({mem_u.mem[16'h0FEF], mem_u.mem[16'h0FEE]}, 16'h5100);
    chk({mem_u.mem[16'h0FED], mem_u.mem[16'h0FEC]}, 16'hA55A);
    chk({mem_u.mem[16'h0FEB], mem_u.mem[16'h0FEA]}, 16'h1234);
    go(`CSB_OP_POP_RP, 8'h00, 1, 20'h1, 1'b0);
    chk(rd, 16'h1234);
    chk(rl, 1'b1);
    go(`CSB_OP_POP_RP, 8'h00, 1, 20'h1, 1'b0);
    chk(rd, 16'hA55A);
    go(`CSB_OP_POP_PSW, 8'h00, 3, 20'h2, 1'b0);
    chk({o_psw, o_stack_ptr}, 24'h510FF0);
    $display("stack test done");
    go(`CSB_OP_JMP_SHORT, 8'h00, 3, 20'hFFFF2, 1'b1);
    go(`CSB_OP_JMP_LONG, 8'h00, 3, 20'h00103, 1'b1);
    go(`CSB_OP_JC, 8'h01, 4, 20'hFFFF2, 1'b1);
    go(`CSB_OP_JC, 8'h00, 2, 20'h2, 1'b0);
    go(`CSB_OP_JNC, 8'h00, 4, 20'hFFFF2, 1'b1);
    go(`CSB_OP_JZ, 8'h40, 4, 20'hFFFF2, 1'b1);
    go(`CSB_OP_JNZ, 8'h40, 2, 20'h2, 1'b0);
    go(`CSB_OP_JH, 8'h00, 4, 20'hFFFF3, 1'b1);
    go(`CSB_OP_JH, 8'h01, 2, 20'h3, 1'b0);
    go(`CSB_OP_JNH, 8'h40, 4, 20'hFFFF3, 1'b1);
    $display("branch test done");
    bj(`CSB_OP_JBT, `CSB_BM_SADDR, 1, 0, 5, 20'hFFFF4);
    bj(`CSB_OP_JBF, `CSB_BM_SFR, 1, 0, 3, 20'h4);
    bj(`CSB_OP_JBT, `CSB_BM_ACC, 1, 0, 5, 20'hFFFF3);
    bj(`CSB_OP_JBF, `CSB_BM_HL, 0, 1, 8, 20'hFFFF3);
    bj(`CSB_OP_JBT, `CSB_BM_HL, 0, 0, 3, 20'h3);
    bj(`CSB_OP_JBT, `CSB_BM_ESHL, 1, 0, 6, 20'hFFFF4);
    bj(`CSB_OP_JBF, `CSB_BM_ESHL, 1, 1, 7, 20'h4);
    bj(`CSB_OP_JBTCLR, `CSB_BM_SADDR, 1, 0, 5, 20'hFFFF4);
    chk(cl, 1'b1);
    bj(`CSB_OP_JBTCLR, `CSB_BM_SFR, 0, 0, 3, 20'h4);
    chk(cl, 1'b0);
    i_bit_mode <= `CSB_BM_PSW;
    go(`CSB_OP_JBTCLR, 8'h11, 7, 20'hFFFF4, 1'b1);
    chk(o_psw, 8'h01);
    $display("bit test done");
    skp(`CSB_OP_SKC, 8'h01, 1'b1);
    skp(`CSB_OP_SKIP_ON_NO_CARRY, 8'h01, 1'b0);
    skp(`CSB_OP_SKZ, 8'h40, 1'b1);
    skp(`CSB_OP_SKIP_ON_NONZERO, 8'h40, 1'b0);
    skp(`CSB_OP_SKH, 8'h00, 1'b1);
    skp(`CSB_OP_SKIP_ON_NOT_HIGHER, 8'h00, 1'b0);
    $display("skip test done");
    for (int b = 0; b < 4; b++) begin
      i_bank <= b[1:0];
      go(`CSB_OP_SEL, 8'h51, 1, 20'h2, 1'b0);
      chk(o_psw, {2'b01, b[1], 1'b1, b[0], 3'b001});
    end
    go(`CSB_OP_EI, 8'h00, 4, 20'h3, 1'b0);
    chk(o_psw, 8'h80);
    go(`CSB_OP_DI, 8'hC1, 4, 20'h3, 1'b0);
    chk(o_psw, 8'h41);
    go(`CSB_OP_NOP, 8'h41, 1, 20'h1, 1'b0);
    chk({o_stack_ptr, o_psw}, 24'h0FF041);
    // Unknown code retires as a one-byte no-op and is flagged
    go(5'h1F, 8'h41, 1, 20'h1, 1'b0);
    chk(bd, 1'b1);
    // Direct program counter write outside an accept edge
    @(posedge i_clk);
    i_pc_wr <= 1'b1;
    i_pc_wdata <= 20'h12345;
    @(posedge i_clk);
    i_pc_wr <= 1'b0;
    #1;
    chk(o_pc, 20'h12345);
    stby(`CSB_OP_HALT, 1'b1);
    stby(`CSB_OP_STOP, 1'b0);
    $display("control test done");
    test_done();
  end
endmodule
`default_nettype wire
